//--- rtl/cpom_defines.vh
// Register indices, field positions, reset values and limits for the
// identification override and performance window register bank.
// Assumes it is included by its bare name from the design files.
`ifndef CPOM_DEFINES_VH
`define CPOM_DEFINES_VH

// Register indices as presented in ECX
`define CPOM_IDX_SIGNATURE 32'h8086_0000
`define CPOM_IDX_VENDOR0 32'h8086_0001
`define CPOM_IDX_VENDOR1 32'h8086_0002
`define CPOM_IDX_VENDOR2 32'h8086_0003
`define CPOM_IDX_FEATMASK 32'h8086_0004
`define CPOM_IDX_BOOTREV 32'h8086_0074
`define CPOM_IDX_PERFWIN 32'h8086_8010

// Identification functions as presented in EAX
`define CPOM_FUNC_VENDOR 32'h0000_0000
`define CPOM_FUNC_SIGNATURE 32'h0000_0001

// Signature field layout, one nibble each, bits 63..16 reserved
`define CPOM_SIG_STEP_LSB 0
`define CPOM_SIG_MODEL_LSB 4
`define CPOM_SIG_FAMILY_LSB 8
`define CPOM_SIG_TYPE_LSB 12
`define CPOM_SIG_WIDTH 16

// Performance window limits and reset values
`define CPOM_PERF_MAX 32'h0000_0064
`define CPOM_PERF_MIN 32'h0000_0000
`define CPOM_PERF_HI_RST 7'h64
`define CPOM_PERF_LO_RST 7'h00

// Feature mask reset: every flag passes
`define CPOM_MASK_RST 32'hFFFF_FFFF

`endif

//--- rtl/cpom_round.v
// Rounds a performance bound of 0..100 to the nearest supported level.
// Assumes levels are spread evenly over 0..100 and LEVELS is at least 2.
`timescale 1ns/100ps

module cpom_round #(
    parameter LEVELS = 5
) (
    // Requested bound, already checked to be 0..100
    input wire [6:0] i_value,
    // Nearest supported level
    output wire [6:0] o_level
);

    localparam [31:0] STEPS = LEVELS - 1;

    wire [31:0] value_ext;
    wire [31:0] numer;
    wire [31:0] index;
    wire [31:0] level;

    assign value_ext = {25'h000_0000, i_value};
    // Adding half a step before the floor makes a midway value go up
    assign numer = value_ext * STEPS * 32'h0000_0002 + 32'h0000_0064;
    assign index = numer / 32'h0000_00C8;
    assign level = (index * 32'h0000_0064) / STEPS;
    assign o_level = level[6:0];

endmodule // cpom_round

//--- rtl/cpom_top.v
// Model-specific register bank that overrides identification reports
// and holds the performance window control with range checking.
// Assumes one register access request per cycle from the core, and that
// the identification query port is sampled on the core clock.
`timescale 1ns/100ps
`include "cpom_defines.vh"

module cpom_top #(
    // Number of supported performance levels
    parameter PERF_LEVELS = 5,
    // Native identity values; the defaults are arbitrary
    parameter [15:0] NATIVE_SIGNATURE = 16'h0000,
    parameter [31:0] NATIVE_VENDOR0 = 32'h6E6F_6E65,
    parameter [31:0] NATIVE_VENDOR1 = 32'h6E6F_6E65,
    parameter [31:0] NATIVE_VENDOR2 = 32'h6E6F_6E65,
    parameter [31:0] NATIVE_MAX_FUNC = 32'h0000_0001,
    parameter [31:0] NATIVE_FEATURES = 32'h0000_0000,
    // Software revision report; the defaults are arbitrary
    parameter [31:0] BOOT_REVISION = 32'h0000_0000,
    parameter [31:0] BUILD_NUMBER = 32'h0000_0000
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_b,
    // Register access from the read and write instructions
    input wire i_msr_req,
    input wire i_msr_wr,
    input wire [31:0] i_msr_index,
    input wire [31:0] i_msr_wdata_hi,
    input wire [31:0] i_msr_wdata_lo,
    output wire o_msr_done,
    output wire o_msr_gp,
    output wire [31:0] o_msr_rdata_hi,
    output wire [31:0] o_msr_rdata_lo,
    // Identification query
    input wire i_id_req,
    input wire [31:0] i_id_func,
    output wire o_id_done,
    output wire o_id_hit,
    output wire [31:0] o_id_eax,
    output wire [31:0] o_id_ebx,
    output wire [31:0] o_id_ecx,
    output wire [31:0] o_id_edx,
    // Performance window in force
    output wire [6:0] o_perf_upper,
    output wire [6:0] o_perf_lower,
    output wire o_perf_fixed,
    output wire o_perf_scaling_off,
    output wire o_perf_minimum
);

    // Stored registers
    reg [15:0] signature_r;
    reg [63:0] vendor0_r;
    reg [63:0] vendor1_r;
    reg [63:0] vendor2_r;
    reg [31:0] feat_mask_r;
    reg [6:0] perf_hi_r;
    reg [6:0] perf_lo_r;

    // Access answer
    reg done_r;
    reg gp_r;
    reg [31:0] rdata_hi_r;
    reg [31:0] rdata_lo_r;
    reg [31:0] rdata_hi_nxt;
    reg [31:0] rdata_lo_nxt;
    reg gp_nxt;

    // Identification answer
    reg id_done_r;
    reg id_hit_r;
    reg [31:0] id_eax_r;
    reg [31:0] id_ebx_r;
    reg [31:0] id_ecx_r;
    reg [31:0] id_edx_r;
    reg id_hit_nxt;
    reg [31:0] id_eax_nxt;
    reg [31:0] id_ebx_nxt;
    reg [31:0] id_ecx_nxt;
    reg [31:0] id_edx_nxt;

    // Index decode
    wire sel_sig;
    wire sel_vnd0;
    wire sel_vnd1;
    wire sel_vnd2;
    wire sel_mask;
    wire sel_rev;
    wire sel_perf;
    wire sel_any;

    assign sel_sig = (i_msr_index == `CPOM_IDX_SIGNATURE);
    assign sel_vnd0 = (i_msr_index == `CPOM_IDX_VENDOR0);
    assign sel_vnd1 = (i_msr_index == `CPOM_IDX_VENDOR1);
    assign sel_vnd2 = (i_msr_index == `CPOM_IDX_VENDOR2);
    assign sel_mask = (i_msr_index == `CPOM_IDX_FEATMASK);
    assign sel_rev = (i_msr_index == `CPOM_IDX_BOOTREV);
    assign sel_perf = (i_msr_index == `CPOM_IDX_PERFWIN);
    assign sel_any = sel_sig | sel_vnd0 | sel_vnd1 | sel_vnd2 |
                     sel_mask | sel_rev | sel_perf;

    // Write checks
    wire sig_rsvd_set;
    wire mask_rsvd_set;
    wire perf_range_bad;
    wire perf_order_bad;
    wire perf_bad;

    assign sig_rsvd_set = (i_msr_wdata_hi != 32'h0000_0000) |
                          (i_msr_wdata_lo[31:`CPOM_SIG_WIDTH] !=
                           16'h0000);
    assign mask_rsvd_set = (i_msr_wdata_hi != 32'h0000_0000);
    assign perf_range_bad = (i_msr_wdata_hi > `CPOM_PERF_MAX) |
                            (i_msr_wdata_lo > `CPOM_PERF_MAX);
    assign perf_order_bad = (i_msr_wdata_lo > i_msr_wdata_hi);
    assign perf_bad = perf_range_bad | perf_order_bad;

    // Rounded bounds of the value being written
    wire [6:0] round_hi;
    wire [6:0] round_lo;

    cpom_round #(
        .LEVELS(PERF_LEVELS)
    ) u_round_hi (
        .i_value(i_msr_wdata_hi[6:0]),
        .o_level(round_hi)
    );

    cpom_round #(
        .LEVELS(PERF_LEVELS)
    ) u_round_lo (
        .i_value(i_msr_wdata_lo[6:0]),
        .o_level(round_lo)
    );

    // Fault decision for the current access
    always @* begin
        gp_nxt = 1'b0;
        if (!sel_any) begin
            gp_nxt = 1'b1;
        end else if (i_msr_wr) begin
            if (sel_sig && sig_rsvd_set) begin
                gp_nxt = 1'b1;
            end else if (sel_mask && mask_rsvd_set) begin
                gp_nxt = 1'b1;
            end else if (sel_perf && perf_bad) begin
                gp_nxt = 1'b1;
            end
        end
    end

    // Read data: high half to EDX, low half to EAX
    always @* begin
        rdata_hi_nxt = 32'h0000_0000;
        rdata_lo_nxt = 32'h0000_0000;
        case (1'b1)
            sel_sig: begin
                rdata_lo_nxt = {16'h0000, signature_r};
            end
            sel_vnd0: begin
                rdata_hi_nxt = vendor0_r[63:32];
                rdata_lo_nxt = vendor0_r[31:0];
            end
            sel_vnd1: begin
                rdata_hi_nxt = vendor1_r[63:32];
                rdata_lo_nxt = vendor1_r[31:0];
            end
            sel_vnd2: begin
                rdata_hi_nxt = vendor2_r[63:32];
                rdata_lo_nxt = vendor2_r[31:0];
            end
            sel_mask: begin
                rdata_lo_nxt = feat_mask_r;
            end
            sel_rev: begin
                rdata_hi_nxt = BUILD_NUMBER;
                rdata_lo_nxt = BOOT_REVISION;
            end
            sel_perf: begin
                rdata_hi_nxt = {25'h000_0000, perf_hi_r};
                rdata_lo_nxt = {25'h000_0000, perf_lo_r};
            end
            default: begin
                rdata_hi_nxt = 32'h0000_0000;
                rdata_lo_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Register updates; a faulting write leaves every register untouched
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            signature_r <= NATIVE_SIGNATURE;
            vendor0_r <= {32'h0000_0000, NATIVE_VENDOR0};
            vendor1_r <= {32'h0000_0000, NATIVE_VENDOR1};
            vendor2_r <= {32'h0000_0000, NATIVE_VENDOR2};
            feat_mask_r <= `CPOM_MASK_RST;
            perf_hi_r <= `CPOM_PERF_HI_RST;
            perf_lo_r <= `CPOM_PERF_LO_RST;
        end else if (i_msr_req && i_msr_wr && !gp_nxt) begin
            if (sel_sig) begin
                signature_r <= i_msr_wdata_lo[15:0];
            end
            if (sel_vnd0) begin
                vendor0_r <= {i_msr_wdata_hi, i_msr_wdata_lo};
            end
            if (sel_vnd1) begin
                vendor1_r <= {i_msr_wdata_hi, i_msr_wdata_lo};
            end
            if (sel_vnd2) begin
                vendor2_r <= {i_msr_wdata_hi, i_msr_wdata_lo};
            end
            if (sel_mask) begin
                feat_mask_r <= i_msr_wdata_lo;
            end
            // Rounded values are stored, so a read shows what is in force
            if (sel_perf) begin
                perf_hi_r <= round_hi;
                perf_lo_r <= round_lo;
            end
        end
    end

    // Access answer, one cycle after the request
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_r <= 1'b0;
            gp_r <= 1'b0;
            rdata_hi_r <= 32'h0000_0000;
            rdata_lo_r <= 32'h0000_0000;
        end else begin
            done_r <= i_msr_req;
            gp_r <= i_msr_req & gp_nxt;
            if (i_msr_req && !i_msr_wr && !gp_nxt) begin
                rdata_hi_r <= rdata_hi_nxt;
                rdata_lo_r <= rdata_lo_nxt;
            end
        end
    end

    // Identification answer
    always @* begin
        id_hit_nxt = 1'b0;
        id_eax_nxt = 32'h0000_0000;
        id_ebx_nxt = 32'h0000_0000;
        id_ecx_nxt = 32'h0000_0000;
        id_edx_nxt = 32'h0000_0000;
        case (i_id_func)
            `CPOM_FUNC_VENDOR: begin
                id_hit_nxt = 1'b1;
                id_eax_nxt = NATIVE_MAX_FUNC;
                // Only the low half of each word reaches the report
                id_ebx_nxt = vendor0_r[31:0];
                id_edx_nxt = vendor1_r[31:0];
                id_ecx_nxt = vendor2_r[31:0];
            end
            `CPOM_FUNC_SIGNATURE: begin
                id_hit_nxt = 1'b1;
                id_eax_nxt = {16'h0000, signature_r};
                id_edx_nxt = NATIVE_FEATURES & feat_mask_r;
            end
            default: begin
                id_hit_nxt = 1'b0;
            end
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            id_done_r <= 1'b0;
            id_hit_r <= 1'b0;
            id_eax_r <= 32'h0000_0000;
            id_ebx_r <= 32'h0000_0000;
            id_ecx_r <= 32'h0000_0000;
            id_edx_r <= 32'h0000_0000;
        end else begin
            id_done_r <= i_id_req;
            if (i_id_req) begin
                id_hit_r <= id_hit_nxt;
                id_eax_r <= id_eax_nxt;
                id_ebx_r <= id_ebx_nxt;
                id_ecx_r <= id_ecx_nxt;
                id_edx_r <= id_edx_nxt;
            end
        end
    end

    assign o_msr_done = done_r;
    assign o_msr_gp = gp_r;
    assign o_msr_rdata_hi = rdata_hi_r;
    assign o_msr_rdata_lo = rdata_lo_r;
    assign o_id_done = id_done_r;
    assign o_id_hit = id_hit_r;
    assign o_id_eax = id_eax_r;
    assign o_id_ebx = id_ebx_r;
    assign o_id_ecx = id_ecx_r;
    assign o_id_edx = id_edx_r;

    // Mode flags of the window in force
    assign o_perf_upper = perf_hi_r;
    assign o_perf_lower = perf_lo_r;
    assign o_perf_fixed = (perf_hi_r == perf_lo_r);
    assign o_perf_scaling_off = (perf_hi_r == `CPOM_PERF_HI_RST) &&
                                (perf_lo_r == `CPOM_PERF_HI_RST);
    assign o_perf_minimum = (perf_hi_r == `CPOM_PERF_LO_RST) &&
                            (perf_lo_r == `CPOM_PERF_LO_RST);

endmodule // cpom_top

//--- verif/cpom_chk_properties.sv
// Concurrent checks on the override and performance window bank ports.
// Assumes it is bound into cpom_top and sees only that module's ports.
`timescale 1ns/100ps
`include "cpom_defines.vh"

module cpom_chk #(
    parameter PERF_LEVELS = 5
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_b,
    // Register access
    input wire i_msr_req,
    input wire i_msr_wr,
    input wire [31:0] i_msr_index,
    input wire [31:0] i_msr_wdata_hi,
    input wire [31:0] i_msr_wdata_lo,
    input wire o_msr_done,
    input wire o_msr_gp,
    input wire [31:0] o_msr_rdata_hi,
    // Identification query and window in force
    input wire i_id_req,
    input wire [31:0] i_id_func,
    input wire o_id_done,
    input wire o_id_hit,
    input wire [6:0] o_perf_upper,
    input wire [6:0] o_perf_lower,
    input wire o_perf_fixed,
    input wire o_perf_scaling_off,
    input wire o_perf_minimum
);
    wire idx_known = i_msr_index == `CPOM_IDX_SIGNATURE ||
        i_msr_index == `CPOM_IDX_VENDOR0 || i_msr_index == `CPOM_IDX_VENDOR1 ||
        i_msr_index == `CPOM_IDX_VENDOR2 || i_msr_index == `CPOM_IDX_FEATMASK ||
        i_msr_index == `CPOM_IDX_BOOTREV || i_msr_index == `CPOM_IDX_PERFWIN;
    // Full 32-bit compares: a huge bound must not alias into range
    wire perf_bad = i_msr_wr && i_msr_index == `CPOM_IDX_PERFWIN &&
        (i_msr_wdata_hi > `CPOM_PERF_MAX || i_msr_wdata_lo > `CPOM_PERF_MAX ||
        i_msr_wdata_lo > i_msr_wdata_hi);
    wire perf_rd = !i_msr_wr && i_msr_index == `CPOM_IDX_PERFWIN;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_done_follows;
        i_msr_req |=> o_msr_done;
    endproperty
    a_done_follows: assert property (p_done_follows)
        else $error("access not answered one cycle later");
    property p_done_caused;
        o_msr_done |-> $past(i_msr_req);
    endproperty
    a_done_caused: assert property (p_done_caused)
        else $error("answer without a request");
    property p_gp_unmapped;
        i_msr_req && !idx_known |=> o_msr_gp;
    endproperty
    a_gp_unmapped: assert property (p_gp_unmapped)
        else $error("unmapped index did not fault");
    property p_gp_with_done;
        o_msr_gp |-> o_msr_done;
    endproperty
    a_gp_with_done: assert property (p_gp_with_done)
        else $error("fault without answer");
    property p_gp_perf;
        i_msr_req && perf_bad |=> o_msr_gp && $stable(o_perf_upper) &&
            $stable(o_perf_lower);
    endproperty
    a_gp_perf: assert property (p_gp_perf)
        else $error("bad window write accepted");
    property p_perf_read;
        i_msr_req && perf_rd |=> o_msr_rdata_hi == {25'h000_0000, o_perf_upper};
    endproperty
    a_perf_read: assert property (p_perf_read)
        else $error("window read differs from bound in force");
    property p_window_order;
        o_perf_lower <= o_perf_upper && o_perf_upper <= 7'h64;
    endproperty
    a_window_order: assert property (p_window_order)
        else $error("window out of order or range");
    property p_fixed;
        o_perf_fixed == (o_perf_upper == o_perf_lower);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed level flag wrong");
    property p_scaling_off;
        o_perf_scaling_off == (o_perf_upper == 7'h64 && o_perf_lower == 7'h64);
    endproperty
    a_scaling_off: assert property (p_scaling_off)
        else $error("scaling off flag wrong");
    property p_minimum;
        o_perf_minimum == (o_perf_upper == 7'h00 && o_perf_lower == 7'h00);
    endproperty
    a_minimum: assert property (p_minimum)
        else $error("minimum flag wrong");
    property p_id_answer;
        i_id_req |=> o_id_done && o_id_hit == ($past(i_id_func) <= 32'h0000_0001);
    endproperty
    a_id_answer: assert property (p_id_answer)
        else $error("identification answer wrong");
endmodule // cpom_chk

bind cpom_top cpom_chk #(.PERF_LEVELS(PERF_LEVELS)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_msr_req(i_msr_req),
    .i_msr_wr(i_msr_wr), .i_msr_index(i_msr_index),
    .i_msr_wdata_hi(i_msr_wdata_hi), .i_msr_wdata_lo(i_msr_wdata_lo),
    .o_msr_done(o_msr_done), .o_msr_gp(o_msr_gp),
    .o_msr_rdata_hi(o_msr_rdata_hi), .i_id_req(i_id_req),
    .i_id_func(i_id_func), .o_id_done(o_id_done), .o_id_hit(o_id_hit),
    .o_perf_upper(o_perf_upper), .o_perf_lower(o_perf_lower),
    .o_perf_fixed(o_perf_fixed), .o_perf_scaling_off(o_perf_scaling_off),
    .o_perf_minimum(o_perf_minimum));

//--- verif/cpuid_override_perf_window_msrs_tb_top.sv
// Self-checking bench for the override and performance window bank.
// Assumes cpom_top and its bound checker are compiled first.
`timescale 1ns/100ps
`include "cpom_defines.vh"

module cpuid_override_perf_window_msrs_tb_top;
    // Native identity values are arbitrary
    localparam [15:0] SIG = 16'h0123;
    localparam [31:0] V0 = 32'h1111_2222;
    localparam [31:0] V1 = 32'h3333_4444;
    localparam [31:0] V2 = 32'h5555_6666;
    localparam [31:0] MAXF = 32'h0000_0001;
    localparam [31:0] FEAT = 32'hA5A5_5A5A;
    localparam [31:0] REV = 32'h0000_0042;
    localparam [31:0] BLD = 32'h0000_0133;
    reg i_ref_clk, i_rst_b, i_msr_req, i_msr_wr, i_id_req;
    reg [31:0] i_msr_index, i_msr_wdata_hi, i_msr_wdata_lo, i_id_func;
    wire o_msr_done, o_msr_gp, o_id_done, o_id_hit, o_perf_fixed;
    wire o_perf_scaling_off, o_perf_minimum;
    wire [31:0] o_msr_rdata_hi, o_msr_rdata_lo, o_id_eax, o_id_ebx;
    wire [31:0] o_id_ecx, o_id_edx;
    wire [6:0] o_perf_upper, o_perf_lower;
    integer mismatches, compares, k;
    reg [31:0] up, lw;

    // Three levels put the tie points 25 and 75 on integers
    cpom_top #(.PERF_LEVELS(3), .NATIVE_SIGNATURE(SIG), .NATIVE_VENDOR0(V0),
        .NATIVE_VENDOR1(V1), .NATIVE_VENDOR2(V2), .NATIVE_MAX_FUNC(MAXF),
        .NATIVE_FEATURES(FEAT), .BOOT_REVISION(REV), .BUILD_NUMBER(BLD)
    ) u_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_msr_req(i_msr_req),
        .i_msr_wr(i_msr_wr), .i_msr_index(i_msr_index),
        .i_msr_wdata_hi(i_msr_wdata_hi), .i_msr_wdata_lo(i_msr_wdata_lo),
        .o_msr_done(o_msr_done), .o_msr_gp(o_msr_gp),
        .o_msr_rdata_hi(o_msr_rdata_hi), .o_msr_rdata_lo(o_msr_rdata_lo),
        .i_id_req(i_id_req), .i_id_func(i_id_func), .o_id_done(o_id_done),
        .o_id_hit(o_id_hit), .o_id_eax(o_id_eax), .o_id_ebx(o_id_ebx),
        .o_id_ecx(o_id_ecx), .o_id_edx(o_id_edx),
        .o_perf_upper(o_perf_upper), .o_perf_lower(o_perf_lower),
        .o_perf_fixed(o_perf_fixed), .o_perf_scaling_off(o_perf_scaling_off),
        .o_perf_minimum(o_perf_minimum));

    task cmp(input string name, input [31:0] exp, input [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task msr(input wr, input [31:0] idx, hi, lo, input gp);
        @(posedge i_ref_clk) #1;
        i_msr_req = 1'b1;
        i_msr_wr = wr;
        i_msr_index = idx;
        i_msr_wdata_hi = hi;
        i_msr_wdata_lo = lo;
        @(posedge i_ref_clk) #1;
        i_msr_req = 1'b0;
        cmp("done", 32'h0000_0001, {31'h0, o_msr_done});
        cmp("fault", {31'h0, gp}, {31'h0, o_msr_gp});
    endtask

    task rd(input [31:0] idx, hi, lo, input gp);
        msr(1'b0, idx, 32'h0000_0000, 32'h0000_0000, gp);
        if (!gp) begin
            cmp("read hi", hi, o_msr_rdata_hi);
            cmp("read lo", lo, o_msr_rdata_lo);
        end
    endtask

    task idq(input [31:0] f, a, b, c, d);
        @(posedge i_ref_clk) #1;
        i_id_req = 1'b1;
        i_id_func = f;
        @(posedge i_ref_clk) #1;
        i_id_req = 1'b0;
        cmp("id done", 32'h0000_0001, {31'h0, o_id_done});
        cmp("id hit", {31'h0, f <= 32'h0000_0001}, {31'h0, o_id_hit});
        cmp("eax", a, o_id_eax);
        cmp("ebx", b, o_id_ebx);
        cmp("ecx", c, o_id_ecx);
        cmp("edx", d, o_id_edx);
    endtask

    // Nearest multiple of 50, ties upward
    task pw(input [31:0] hi, lo, input gp);
        msr(1'b1, `CPOM_IDX_PERFWIN, hi, lo, gp);
        if (!gp) begin
            up = (hi + 32'h0000_0019) / 32'h0000_0032 * 32'h0000_0032;
            lw = (lo + 32'h0000_0019) / 32'h0000_0032 * 32'h0000_0032;
        end
        cmp("upper", up, {25'h0, o_perf_upper});
        cmp("lower", lw, {25'h0, o_perf_lower});
        cmp("fixed", {31'h0, (up == lw)}, {31'h0, o_perf_fixed});
        cmp("scaling off",
            {31'h0, (up == `CPOM_PERF_MAX && lw == `CPOM_PERF_MAX)},
            {31'h0, o_perf_scaling_off});
        cmp("minimum",
            {31'h0, (up == `CPOM_PERF_MIN && lw == `CPOM_PERF_MIN)},
            {31'h0, o_perf_minimum});
        rd(`CPOM_IDX_PERFWIN, up, lw, 1'b0);
    endtask

    task wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Whole run needs about 1 us; a hang is cut well after that
    initial begin
        #20000;
        mismatches = mismatches + 1;
        wrap_up;
    end

    initial begin
        {i_msr_req, i_msr_wr, i_id_req, i_rst_b} = 4'h0;
        {i_msr_index, i_msr_wdata_hi, i_msr_wdata_lo, i_id_func} = 128'h0;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge i_ref_clk);
        #1 i_rst_b = 1'b1;
        rd(`CPOM_IDX_SIGNATURE, 32'h0, {16'h0, SIG}, 1'b0);
        rd(`CPOM_IDX_FEATMASK, 32'h0, `CPOM_MASK_RST, 1'b0);
        rd(`CPOM_IDX_BOOTREV, BLD, REV, 1'b0);
        rd(`CPOM_IDX_PERFWIN, 32'h0000_0064, 32'h0, 1'b0);
        idq(32'h1, {16'h0, SIG}, 32'h0, 32'h0, FEAT);
        idq(32'h0, MAXF, V0, V2, V1);
        idq(32'h2, 32'h0, 32'h0, 32'h0, 32'h0);
        rd(32'h8086_0005, 32'h0, 32'h0, 1'b1);
        msr(1'b1, 32'h8086_8011, 32'h0, 32'h0, 1'b1);
        msr(1'b1, `CPOM_IDX_SIGNATURE, 32'h0, 32'h0000_4321, 1'b0);
        msr(1'b1, `CPOM_IDX_SIGNATURE, 32'h1, 32'h0, 1'b1);
        msr(1'b1, `CPOM_IDX_SIGNATURE, 32'h0, 32'h0001_0000, 1'b1);
        idq(32'h1, 32'h0000_4321, 32'h0, 32'h0, FEAT);
        for (k = 0; k < 3; k++) begin
            msr(1'b1, `CPOM_IDX_VENDOR0 + k, 32'h0BAD_0000 + k,
                32'h4000_0000 + k, 1'b0);
        end
        rd(`CPOM_IDX_VENDOR1, 32'h0BAD_0001, 32'h4000_0001, 1'b0);
        idq(32'h0, MAXF, 32'h4000_0000, 32'h4000_0002, 32'h4000_0001);
        msr(1'b1, `CPOM_IDX_FEATMASK, 32'h1, 32'h0, 1'b1);
        msr(1'b1, `CPOM_IDX_FEATMASK, 32'h0, 32'h0000_FF00, 1'b0);
        idq(32'h1, 32'h0000_4321, 32'h0, 32'h0, FEAT & 32'h0000_FF00);
        msr(1'b1, `CPOM_IDX_BOOTREV, 32'h1, 32'h1, 1'b0);
        rd(`CPOM_IDX_BOOTREV, BLD, REV, 1'b0);
        // Support query first; this bank does not serve that function
        idq(32'h8086_0001, 32'h0, 32'h0, 32'h0, 32'h0);
        up = 32'h0000_0064;
        lw = 32'h0000_0000;
        pw(32'h0000_0065, 32'h0, 1'b1);
        pw(32'h0000_0032, 32'h0000_0065, 1'b1);
        pw(32'h8000_0000, 32'h0, 1'b1);
        pw(32'h0000_001E, 32'h0000_003C, 1'b1);
        pw(32'h0000_004A, 32'h0000_0018, 1'b0);
        pw(32'h0000_004B, 32'h0000_0019, 1'b0);
        pw(32'h0000_003C, 32'h0000_0028, 1'b0);
        pw(32'h0000_0064, 32'h0000_0064, 1'b0);
        pw(32'h0, 32'h0, 1'b0);
        // Reset mid-run must bring back native values and default window
        @(posedge i_ref_clk) #1 i_rst_b = 1'b0;
        @(posedge i_ref_clk) #1 i_rst_b = 1'b1;
        rd(`CPOM_IDX_SIGNATURE, 32'h0, {16'h0, SIG}, 1'b0);
        rd(`CPOM_IDX_VENDOR1, 32'h0, V1, 1'b0);
        rd(`CPOM_IDX_PERFWIN, 32'h0000_0064, 32'h0, 1'b0);
        idq(32'h1, {16'h0, SIG}, 32'h0, 32'h0, FEAT);
        wrap_up;
    end
endmodule // cpuid_override_perf_window_msrs_tb_top
